// ===== hw/t1_bit_oriented_code_ctrl.sv
// Bit-oriented code generator, detector and data-link event registers
`timescale 1ns/100ps
`include "boc_cfg.svh"
module t1_bit_oriented_code_ctrl (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Line mode
  input wire logic t1_mode,
  // Parallel register port
  input wire logic reg_cs,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata_q,
  // Framer transmit data-link slot
  input wire logic tx_link_req,
  output logic tx_link_bit_q,
  // Framer receive data-link slot
  input wire logic rx_link_valid,
  input wire logic rx_link_bit,
  // Status to host
  output logic valid_code_status_q,
  output logic irq_q
);

  ////////////////////////////////////////////////////////////////////////////
  // Register port decode

  logic [4:0] ctrl_q;
  logic [5:0] mask_q;
  logic [5:0] ev_q;
  logic [7:0] tx_buf_q;
  logic [7:0] rx_buf_q;
  logic [7:0] match1_q;
  logic [7:0] match2_q;

  wire wr = reg_cs && reg_wr;
  wire rd = reg_cs && reg_rd;
  wire wr_ctrl = wr && (reg_addr == `OFS_CODE_CONTROL);
  wire wr_mask = wr && (reg_addr == `OFS_LINK_EVENT_MASK);
  wire wr_stat = wr && (reg_addr == `OFS_LINK_EVENT_STATUS);
  wire wr_txb = wr && (reg_addr == `OFS_TX_LINK_BUFFER);
  wire wr_m1 = wr && (reg_addr == `OFS_MATCH_PATTERN_ONE);
  wire wr_m2 = wr && (reg_addr == `OFS_MATCH_PATTERN_TWO);

  // Bits 5 to 7 are not stored, so a careless write cannot wake them
  wire [4:0] ctrl_d = wr_ctrl ? reg_wdata[4:0] : ctrl_q;
  wire send_code = ctrl_q[`CC_SEND_CODE];
  wire rx_code_enable = ctrl_q[`CC_RX_CODE_ENABLE];
  wire rx_active = rx_code_enable && t1_mode;
  wire send_active = send_code && t1_mode;
  wire rx_code_reset = wr_ctrl && reg_wdata[`CC_RX_CODE_RESET]
    && !ctrl_q[`CC_RX_CODE_RESET];
  wire enable_rise = ctrl_d[`CC_RX_CODE_ENABLE] && !rx_code_enable;
  wire rx_preset = rx_code_reset || enable_rise;

  wire [7:0] rx_view = rx_code_enable ? {2'h0, rx_buf_q[5:0]} : rx_buf_q;
  wire [7:0] rd_mux =
    (reg_addr == `OFS_LINK_EVENT_STATUS) ? {2'h0, ev_q} :
    (reg_addr == `OFS_LINK_EVENT_MASK) ? {2'h0, mask_q} :
    (reg_addr == `OFS_CODE_CONTROL) ? {3'h0, ctrl_q} :
    (reg_addr == `OFS_RX_LINK_BUFFER) ? rx_view :
    (reg_addr == `OFS_TX_LINK_BUFFER) ? tx_buf_q :
    (reg_addr == `OFS_MATCH_PATTERN_ONE) ? match1_q :
    (reg_addr == `OFS_MATCH_PATTERN_TWO) ? match2_q : `RST_REG8;

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      ctrl_q <= `RST_CTRL5;
      mask_q <= `RST_EV6;
      tx_buf_q <= `RST_REG8;
      match1_q <= `RST_REG8;
      match2_q <= `RST_REG8;
      reg_rdata_q <= `RST_REG8;
    end
    else
    begin
      ctrl_q <= ctrl_d;
      if (wr_mask)
        mask_q <= reg_wdata[5:0];
      if (wr_txb)
        tx_buf_q <= reg_wdata;
      if (wr_m1)
        match1_q <= reg_wdata;
      if (wr_m2)
        match2_q <= reg_wdata;
      if (rd)
        reg_rdata_q <= rd_mux;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmit generator: eight ones, 0, six code bits LSB first, 0

  boc_pkg::tx_state_t tx_state_q;
  boc_pkg::tx_state_t tx_state_d;
  logic [2:0] tx_cnt_q;
  logic [2:0] tx_cnt_d;
  logic [5:0] code_q;
  logic tx_bit_d;
  logic tx_pending_q;

  wire flag_done = (tx_state_q == boc_pkg::TX_FLAG) && (tx_cnt_q == `FLAG_LAST);
  wire load_code = tx_link_req && flag_done && send_active;
  wire tx_empty = load_code && tx_pending_q;

  always_comb
  begin
    tx_state_d = tx_state_q;
    tx_cnt_d = tx_cnt_q;
    if (!send_active && tx_state_q != boc_pkg::TX_CODE && tx_state_q != boc_pkg::TX_TAIL)
      tx_state_d = boc_pkg::TX_IDLE;
    if (!t1_mode)
      tx_state_d = boc_pkg::TX_IDLE;
    else if (tx_link_req)
    begin
      case (tx_state_q)
        boc_pkg::TX_IDLE:
        begin
          if (send_active)
          begin
            tx_state_d = boc_pkg::TX_FLAG;
            tx_cnt_d = 3'h0;
          end
        end
        boc_pkg::TX_FLAG:
        begin
          if (!send_active)
            tx_state_d = boc_pkg::TX_IDLE;
          else if (flag_done)
            tx_state_d = boc_pkg::TX_LEAD;
          else
            tx_cnt_d = tx_cnt_q + 3'h1;
        end
        boc_pkg::TX_LEAD:
        begin
          tx_state_d = boc_pkg::TX_CODE;
          tx_cnt_d = 3'h0;
        end
        boc_pkg::TX_CODE:
        begin
          if (tx_cnt_q == `CODE_LAST)
            tx_state_d = boc_pkg::TX_TAIL;
          else
            tx_cnt_d = tx_cnt_q + 3'h1;
        end
        boc_pkg::TX_TAIL:
        begin
          tx_state_d = send_active ? boc_pkg::TX_FLAG : boc_pkg::TX_IDLE;
          tx_cnt_d = 3'h0;
        end
        default:
          tx_state_d = boc_pkg::TX_IDLE;
      endcase
    end
  end

  // Bit presented for the next slot follows the next state
  always_comb
  begin
    case (tx_state_d)
      boc_pkg::TX_LEAD: tx_bit_d = 1'b0;
      boc_pkg::TX_TAIL: tx_bit_d = 1'b0;
      boc_pkg::TX_CODE: tx_bit_d = code_q[tx_cnt_d];
      default: tx_bit_d = 1'b1;
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      tx_state_q <= boc_pkg::TX_IDLE;
      tx_cnt_q <= 3'h0;
      code_q <= 6'h00;
      tx_link_bit_q <= 1'b1;
      tx_pending_q <= 1'b0;
    end
    else
    begin
      tx_state_q <= tx_state_d;
      tx_cnt_q <= tx_cnt_d;
      tx_link_bit_q <= tx_bit_d;
      if (load_code)
        code_q <= tx_buf_q[5:0];
      tx_pending_q <= wr_txb || (tx_pending_q && !load_code);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive detector

  logic [15:0] win_q;
  logic [5:0] cand_q;
  logic [2:0] rep_q;
  logic [2:0] byte_cnt_q;
  logic [2:0] need;

  wire [15:0] win_d = {win_q[14:0], rx_link_bit};
  wire rx_bit = rx_link_valid && t1_mode;
  wire pat_hit = rx_bit && rx_active && (win_d[15:8] == 8'hFF) && !win_d[7] && !win_d[0];
  wire [5:0] rx_code = {win_d[1], win_d[2], win_d[3], win_d[4], win_d[5], win_d[6]};
  wire [2:0] rep_next = (rx_code == cand_q && rep_q != 3'h7) ? rep_q + 3'h1 :
    (rx_code == cand_q) ? rep_q : 3'h1;

  always_comb
  begin
    case (ctrl_q[`CC_FILTER_HI:`CC_FILTER_LO])
      2'h1: need = `FILT_THREE;
      2'h2: need = `FILT_FIVE;
      2'h3: need = `FILT_SEVEN;
      default: need = `FILT_NONE;
    endcase
  end

  logic gap_hit;
  logic abort_hit;
  logic clear_hit;

  run_counter #(.WIDTH(5), .LIMIT(`GAP_BITS)) gap_run (
    .ref_clk(ref_clk),
    .rst(rst),
    .clr(pat_hit || rx_preset),
    .inc(rx_bit && rx_active),
    .hit(gap_hit)
  );

  run_counter #(.WIDTH(4), .LIMIT(`ABORT_ONES)) ones_run (
    .ref_clk(ref_clk),
    .rst(rst),
    .clr(rx_bit && !rx_link_bit),
    .inc(rx_bit && rx_link_bit),
    .hit(abort_hit)
  );

  // Rearmed only by an abort, so at most one clear event follows each abort
  run_counter #(.WIDTH(5), .LIMIT(`CLEAR_BITS)) clear_run (
    .ref_clk(ref_clk),
    .rst(rst),
    .clr(abort_hit),
    .inc(rx_bit),
    .hit(clear_hit)
  );

  wire qualify = pat_hit && (rep_next == need)
    && (!valid_code_status_q || rx_code != rx_buf_q[5:0]);
  wire lost = gap_hit && valid_code_status_q;
  wire byte_done = rx_bit && !rx_code_enable && (byte_cnt_q == 3'h7);
  wire [7:0] rx_load = rx_code_enable ? {2'h0, rx_code} : win_d[7:0];
  wire rx_fill = qualify || byte_done;
  wire rx_match = rx_fill && (rx_load == match1_q || rx_load == match2_q);

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      win_q <= 16'h0000;
      cand_q <= 6'h00;
      rep_q <= 3'h0;
      byte_cnt_q <= 3'h0;
      rx_buf_q <= `RST_REG8;
      valid_code_status_q <= 1'b0;
    end
    else
    begin
      if (rx_bit)
      begin
        win_q <= win_d;
        byte_cnt_q <= byte_cnt_q + 3'h1;
      end
      if (rx_preset)
      begin
        rep_q <= 3'h0;
        rx_buf_q <= {2'h0, `CODE_PRESET};
        valid_code_status_q <= 1'b0;
      end
      else
      begin
        if (pat_hit)
        begin
          cand_q <= rx_code;
          rep_q <= rep_next;
        end
        else if (gap_hit)
          rep_q <= 3'h0;
        if (rx_fill)
          rx_buf_q <= rx_load;
        if (qualify)
          valid_code_status_q <= 1'b1;
        else if (lost)
        begin
          valid_code_status_q <= 1'b0;
          rx_buf_q <= {2'h0, `CODE_PRESET};
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Event status and interrupt

  wire [5:0] ev_set = {clear_hit, abort_hit, rx_fill, tx_empty, rx_match, qualify};
  wire [5:0] ev_clr = wr_stat ? reg_wdata[5:0] : 6'h00;
  // A new event in the clearing cycle survives
  wire [5:0] ev_d = ev_set | (ev_q & ~ev_clr);

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      ev_q <= `RST_EV6;
      irq_q <= 1'b0;
    end
    else
    begin
      ev_q <= ev_d;
      irq_q <= |(ev_q & mask_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence s_tail_sent;
    tx_state_q == boc_pkg::TX_TAIL && tx_link_req && send_active;
  endsequence

  property p_t1_only;
    !t1_mode |=> tx_state_q == boc_pkg::TX_IDLE && tx_link_bit_q;
  endproperty
  a_t1_only: assert property (p_t1_only) else $error("generator active outside T1");

  property p_code_source;
    load_code |=> code_q == $past(tx_buf_q[5:0]);
  endproperty
  a_code_source: assert property (p_code_source) else $error("code not from buffer");

  property p_start_now;
    tx_state_q == boc_pkg::TX_IDLE && send_active && tx_link_req
      |=> tx_state_q == boc_pkg::TX_FLAG && tx_link_bit_q;
  endproperty
  a_start_now: assert property (p_start_now) else $error("send did not start");

  property p_repeat;
    s_tail_sent |=> tx_state_q == boc_pkg::TX_FLAG && tx_cnt_q == 3'h0;
  endproperty
  a_repeat: assert property (p_repeat) else $error("message not repeated");

  property p_preset;
    enable_rise |=> rx_buf_q == 8'h3F && !valid_code_status_q;
  endproperty
  a_preset: assert property (p_preset) else $error("receive buffer not preset");

  property p_rx_reset;
    rx_code_reset |=> rep_q == 3'h0;
  endproperty
  a_rx_reset: assert property (p_rx_reset) else $error("reset edge ignored");

  property p_change_event;
    qualify |=> ev_q[0] && valid_code_status_q && rx_buf_q[5:0] == $past(rx_code);
  endproperty
  a_change_event: assert property (p_change_event) else $error("change not flagged");

  property p_abort_event;
    abort_hit |=> ev_q[4];
  endproperty
  a_abort_event: assert property (p_abort_event) else $error("abort not flagged");

  property p_clear_event;
    clear_hit |=> ev_q[5];
  endproperty
  a_clear_event: assert property (p_clear_event) else $error("clear not flagged");

  property p_irq;
    (|(ev_q & mask_q)) |=> irq_q;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt not raised");

  property p_latched;
    ev_q[0] && !(wr_stat && reg_wdata[0]) |=> ev_q[0];
  endproperty
  a_latched: assert property (p_latched) else $error("event lost");

endmodule

// ===== hw/boc_cfg.svh
// Register map, field positions, reset values and counts for the bit-oriented code controller
// Behaviour
// - Generator and detector work only while the line runs in T1 mode.
// - Transmitted code is bits 0 to 5 of the transmit link buffer.
// - Setting send_code starts code insertion into the data-link bit at once.
// - Generator sends the eight-ones abort flag by itself.
// - Code messages repeat while send_code stays set, stop when cleared.
// - Bit 4 enables reception; receive buffer then holds the code.
// - While reception is enabled the six code bits preset to all ones.
// - Received code sits in bits 0 to 5; bits 6 and 7 unused.
// - Change of state on a filtered new code or on a nonvalid code; here a nonvalid code sets no event bit.
// - Filter 00 none, 01 three, 10 five, 11 seven equal patterns.
// - A 0-to-1 edge of bit 3 resets the receive code logic.
// - Status bit 0 sets when the detector moves to a valid code.
// - Status bit 1 sets when the receive buffer equals a match pattern.
// - Status bit 2 sets when the transmit link buffer empties.
// - Status bit 3 sets when the receive link buffer fills.
// - Status bit 4 sets on eight consecutive ones received.
// - Status bit 5 sets after 30 link bits without an abort.
// - Mask bit 1 enables, 0 masks the same-position status bit.
`ifndef BOC_CFG_SVH
`define BOC_CFG_SVH

`define OFS_LINK_EVENT_STATUS 8'h24
`define OFS_LINK_EVENT_MASK 8'h25
`define OFS_CODE_CONTROL 8'h37
`define OFS_RX_LINK_BUFFER 8'hC0
`define OFS_TX_LINK_BUFFER 8'hC1
`define OFS_MATCH_PATTERN_ONE 8'hC2
`define OFS_MATCH_PATTERN_TWO 8'hC3

`define CC_SEND_CODE 0
`define CC_FILTER_LO 1
`define CC_FILTER_HI 2
`define CC_RX_CODE_RESET 3
`define CC_RX_CODE_ENABLE 4

`define EV_CODE_CHANGE 0
`define EV_LINK_MATCH 1
`define EV_TX_EMPTY 2
`define EV_RX_FULL 3
`define EV_RX_ABORT 4
`define EV_CODE_CLEAR 5

`define RST_REG8 8'h00
`define RST_CTRL5 5'h00
`define RST_EV6 6'h00
`define CODE_PRESET 6'h3F

`define ABORT_ONES 8
`define CLEAR_BITS 30
`define GAP_BITS 17
`define FLAG_LAST 3'h7
`define CODE_LAST 3'h5
`define FILT_NONE 3'h1
`define FILT_THREE 3'h3
`define FILT_FIVE 3'h5
`define FILT_SEVEN 3'h7

`endif

// ===== hw/boc_pkg.sv
// Types shared by the bit-oriented code controller
package boc_pkg;

  typedef enum logic [4:0] {
    TX_IDLE = 5'h01,
    TX_FLAG = 5'h02,
    TX_LEAD = 5'h04,
    TX_CODE = 5'h08,
    TX_TAIL = 5'h10
  } tx_state_t;

endpackage

// ===== hw/run_counter.sv
// Saturating run counter that pulses once when a run reaches its limit
`timescale 1ns/100ps
module run_counter #(
  parameter int WIDTH = 5,
  parameter int LIMIT = 30
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Control
  input wire logic clr,
  input wire logic inc,
  // Result
  output logic hit
);

  // Refuse a limit that the counter cannot reach
  if (LIMIT < 1 || LIMIT >= (1 << WIDTH))
  begin : g_limit_check
    $error("run_counter: LIMIT does not fit WIDTH");
  end

  logic [WIDTH-1:0] cnt_q;
  wire at_top = (cnt_q == WIDTH'(LIMIT));

  // Saturation keeps the pulse single until the run is broken
  assign hit = inc && !clr && (cnt_q == WIDTH'(LIMIT - 1));

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      cnt_q <= '0;
    else if (clr)
      cnt_q <= '0;
    else if (inc && !at_top)
      cnt_q <= cnt_q + WIDTH'(1);
  end

endmodule

// ===== bench/remote_link_model.sv
// Remote T1 equipment seen through the framer's data-link slots
`timescale 1ns/100ps
module remote_link_model (
  // Clock
  input wire logic ref_clk,
  // Transmit slot
  input wire logic tx_link_bit_q,
  output logic tx_link_req,
  // Receive slot
  output logic rx_link_valid,
  output logic rx_link_bit
);
  int gap = 0;
  logic [63:0] got;

  initial
  begin
    tx_link_req = 1'b0;
    rx_link_valid = 1'b0;
    rx_link_bit = 1'b0;
    got = 64'h0;
  end

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Data line flips between slots so a stale bit never passes for a fresh one
  task automatic put_bit(input logic b);
    @(negedge ref_clk);
    rx_link_valid = 1'b1;
    rx_link_bit = b;
    @(negedge ref_clk);
    rx_link_valid = 1'b0;
    rx_link_bit = ~b;
    repeat (gap) @(negedge ref_clk);
  endtask

  // Eight-ones flag, zero, code LSB first, zero
  task automatic put_code(input logic [5:0] code, input int reps);
    for (int r = 0; r < reps; r++)
    begin
      for (int i = 0; i < 16; i++)
        put_bit((i < 8) ? 1'b1 : (i > 8 && i < 15) ? code[i-9] : 1'b0);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////////////////////
  // Pull n slots from the transmitter, oldest bit in position 0
  task automatic take_bits(input int n);
    for (int i = 0; i < n; i++)
    begin
      @(negedge ref_clk);
      got[i] = tx_link_bit_q;
      tx_link_req = 1'b1;
      @(negedge ref_clk);
      tx_link_req = 1'b0;
      repeat (gap) @(negedge ref_clk);
    end
  endtask
endmodule

// ===== bench/tb_top.sv
// Self-checking bench for the bit-oriented code controller
`timescale 1ns/100ps
`include "boc_cfg.svh"
`define CHK(what, exp, seen) \
  begin \
    checks++; \
    if ((seen) !== (exp)) \
    begin \
      num_errors++; \
      $display("mismatch %s expected %h seen %h", what, exp, seen); \
    end \
  end
module tb_top;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic t1_mode = 1'b0;
  logic reg_cs = 1'b0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata_q;
  logic tx_link_req;
  logic tx_link_bit_q;
  logic rx_link_valid;
  logic rx_link_bit;
  logic valid_code_status_q;
  logic irq_q;
  logic [7:0] v;
  logic [5:0] code;
  int checks = 0;
  int num_errors = 0;

  always #2.5 ref_clk = ~ref_clk;

  t1_bit_oriented_code_ctrl DUT (
    .ref_clk(ref_clk), .rst(rst), .t1_mode(t1_mode), .reg_cs(reg_cs), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q),
    .tx_link_req(tx_link_req), .tx_link_bit_q(tx_link_bit_q), .rx_link_valid(rx_link_valid),
    .rx_link_bit(rx_link_bit), .valid_code_status_q(valid_code_status_q), .irq_q(irq_q));

  remote_link_model remote (
    .ref_clk(ref_clk), .tx_link_bit_q(tx_link_bit_q), .tx_link_req(tx_link_req),
    .rx_link_valid(rx_link_valid), .rx_link_bit(rx_link_bit));

  ////////////////////////////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    reg_cs = 1'b1;
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge ref_clk);
    reg_cs = 1'b0;
    reg_wr = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge ref_clk);
    reg_cs = 1'b1;
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge ref_clk);
    reg_cs = 1'b0;
    reg_rd = 1'b0;
    d = reg_rdata_q;
  endtask

  task automatic summarize();
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic wait_irq();
    for (int n = 0; n < 60 && irq_q !== 1'b1; n++)
      @(negedge ref_clk);
    `CHK("irq wait", 1'b1, irq_q)
    if (irq_q !== 1'b1)
      summarize();
  endtask

  // Consumed slot i: idle one, then repeating 16-bit messages
  function automatic logic tx_exp(input int i, input logic [5:0] c);
    int m;
    if (i == 0)
      return 1'b1;
    m = (i - 1) % 16;
    return (m < 8) ? 1'b1 : (m > 8 && m < 15) ? c[m-9] : 1'b0;
  endfunction

  initial
  begin
    repeat (50000) @(posedge ref_clk);
    num_errors++;
    $display("mismatch watchdog expected done seen hang");
    summarize();
  end

  ////////////////////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (12) @(negedge ref_clk);
    rst = 1'b0;
    `CHK("idle tx bit", 1'b1, tx_link_bit_q)
    rd(`OFS_LINK_EVENT_STATUS, v);
    `CHK("status reset", 8'h00, v)
    rd(`OFS_CODE_CONTROL, v);
    `CHK("control reset", 8'h00, v)
    rd(8'h10, v);
    `CHK("unmapped read", 8'h00, v)
    wr(`OFS_LINK_EVENT_MASK, 8'hFF);
    rd(`OFS_LINK_EVENT_MASK, v);
    `CHK("mask bits", 8'h3F, v)
    wr(`OFS_LINK_EVENT_MASK, 8'h00);
    // Code first, send bit second; upper buffer bits must not reach the line
    wr(`OFS_TX_LINK_BUFFER, 8'hED);
    wr(`OFS_CODE_CONTROL, 8'h01);
    remote.take_bits(20);
    for (int i = 0; i < 20; i++)
      `CHK("tx outside T1", 1'b1, remote.got[i])
    t1_mode = 1'b1;
    remote.take_bits(33);
    for (int i = 0; i < 33; i++)
      `CHK("tx message", tx_exp(i, 6'h2D), remote.got[i])
    rd(`OFS_LINK_EVENT_STATUS, v);
    `CHK("tx empty", 8'h04, v)
    `CHK("masked irq", 1'b0, irq_q)
    wr(`OFS_CODE_CONTROL, 8'h00);
    remote.take_bits(20);
    for (int i = 0; i < 20; i++)
      `CHK("tx stopped", 1'b1, remote.got[i])
    wr(`OFS_LINK_EVENT_STATUS, 8'h3F);
    rd(`OFS_LINK_EVENT_STATUS, v);
    `CHK("status cleared", 8'h00, v)
    // Receive one code with no filtering
    wr(`OFS_LINK_EVENT_MASK, 8'h01);
    wr(`OFS_MATCH_PATTERN_ONE, 8'h12);
    wr(`OFS_CODE_CONTROL, 8'h10);
    rd(`OFS_RX_LINK_BUFFER, v);
    `CHK("rx preset", 8'h3F, v)
    remote.put_code(6'h12, 1);
    wait_irq();
    `CHK("valid status", 1'b1, valid_code_status_q)
    rd(`OFS_LINK_EVENT_STATUS, v);
    `CHK("rx events", 8'h1B, v)
    rd(`OFS_RX_LINK_BUFFER, v);
    `CHK("rx code", 8'h12, v)
    wr(`OFS_LINK_EVENT_STATUS, 8'h01);
    rd(`OFS_LINK_EVENT_STATUS, v);
    `CHK("partial clear", 8'h1A, v)
    `CHK("irq dropped", 1'b0, irq_q)
    // Filter counts 3, 5, 7; the middle one with a slow far end
    for (int f = 1; f < 4; f++)
    begin
      code = 6'h20 + 6'(f);
      remote.gap = (f == 2) ? 3 : 0;
      wr(`OFS_LINK_EVENT_STATUS, 8'h3F);
      wr(`OFS_CODE_CONTROL, 8'h10 | 8'(f * 2));
      remote.put_code(code, 2 * f);
      rd(`OFS_LINK_EVENT_STATUS, v);
      `CHK("filter early", 1'b0, v[`EV_CODE_CHANGE])
      remote.put_code(code, 1);
      rd(`OFS_LINK_EVENT_STATUS, v);
      `CHK("filter count", 1'b1, v[`EV_CODE_CHANGE])
      rd(`OFS_RX_LINK_BUFFER, v);
      `CHK("filtered code", {2'b00, code}, v)
    end
    remote.gap = 0;
    // Silence after an abort: clear event, code no longer valid
    wr(`OFS_LINK_EVENT_STATUS, 8'h3F);
    for (int i = 0; i < 30; i++)
      remote.put_bit(1'b0);
    rd(`OFS_LINK_EVENT_STATUS, v);
    `CHK("clear event", 8'h20, v)
    `CHK("nonvalid", 1'b0, valid_code_status_q)
    rd(`OFS_RX_LINK_BUFFER, v);
    `CHK("rx re-preset", 8'h3F, v)
    // Receive reset acts on the rising edge of the bit only
    wr(`OFS_CODE_CONTROL, 8'h10);
    remote.put_code(6'h12, 1);
    wr(`OFS_CODE_CONTROL, 8'h18);
    @(negedge ref_clk);
    `CHK("rx reset", 1'b0, valid_code_status_q)
    remote.put_code(6'h12, 1);
    wr(`OFS_CODE_CONTROL, 8'h18);
    @(negedge ref_clk);
    `CHK("held reset bit", 1'b1, valid_code_status_q)
    wr(`OFS_CODE_CONTROL, 8'h10);
    wr(`OFS_CODE_CONTROL, 8'h18);
    @(negedge ref_clk);
    `CHK("rearmed reset", 1'b0, valid_code_status_q)
    summarize();
  end
endmodule
